// File: lit_pkg.sv
// constants and types shared by the interval timekeeper files
package lit_pkg;
   // ==========================================================
   // register byte addresses on the wishbone slave
   localparam logic [4:0] ADDR_CONTROL = 5'h00;
   localparam logic [4:0] ADDR_COMPARE = 5'h04;
   localparam logic [4:0] ADDR_FRACTION = 5'h08;
   localparam logic [4:0] ADDR_SECONDS = 5'h0C;
   localparam logic [4:0] ADDR_MINUTES = 5'h10;
   localparam logic [4:0] ADDR_HOURS = 5'h14;
   localparam logic [4:0] ADDR_INTERVAL = 5'h18;
   localparam logic [4:0] ADDR_IRQ_ENABLE = 5'h1C;
   localparam int ADDR_W = 5;

   // ==========================================================
   // control register fields
   localparam int CTL_GATE = 0;
   localparam int CTL_COUNT_EN = 1;
   localparam int CTL_FLAG = 2;
   localparam int CTL_SINGLE = 3;
   localparam int CTL_TB_LOW = 4;
   localparam int CTL_TB_HIGH = 5;
   localparam int CTL_DAY_WRAP = 6;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] BYTE_RESET = 8'h00;

   // ==========================================================
   // time fields, in carry order
   localparam int FIELDS = 4;
   localparam logic [1:0] FIELD_FRACTION = 2'h0;
   localparam logic [1:0] FIELD_SECONDS = 2'h1;
   localparam logic [1:0] FIELD_MINUTES = 2'h2;
   localparam logic [1:0] FIELD_HOURS = 2'h3;
   localparam logic [7:0] FRACTION_LAST = 8'h7F;
   localparam logic [7:0] SIXTY_LAST = 8'h3B;
   localparam logic [7:0] HOUR_LAST_DAY = 8'h17;
   localparam logic [7:0] HOUR_LAST_FULL = 8'hFF;

   // ==========================================================
   // crystal timing: 32768 Hz divided by 256 gives 128 ticks per second
   localparam int XTAL_HZ = 32768;
   localparam int TICK_HZ = 128;
   localparam int PRESCALE = XTAL_HZ / TICK_HZ;
   localparam logic [7:0] PRESCALE_LAST = 8'(PRESCALE - 1);
   localparam logic [15:0] WAKE_VECTOR = 16'h0053;

   typedef enum logic [1:0]
   {
      BUS_IDLE = 2'b01,
      BUS_ACK = 2'b10
   } lit_bus_state_t;
endpackage

// File: lit_time_if.sv
// bundle between the bus/interval logic, the tick source and the time chain
`timescale 1ns/10ps
interface lit_time_if;
   import lit_pkg::*;
   logic gate;
   logic day_wrap;
   logic tick;
   logic [FIELDS-1:0] wr_en;
   logic [7:0] wr_data;
   logic [7:0] count [FIELDS];
   logic [FIELDS-1:0] ovf;

   modport gen (input gate, output tick);
   modport keeper (input gate, day_wrap, tick, wr_en, wr_data, output count, ovf);
   modport ctl (output gate, day_wrap, wr_en, wr_data, input tick, count, ovf);
endinterface

// File: lit_tick_gen.sv
// crystal pin synchroniser and divider giving the 1/128 second tick
`timescale 1ns/10ps
module lit_tick_gen
   import lit_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic xtal_i,
   lit_time_if.gen tif
);
   logic [2:0] sync;
   logic level;
   logic [7:0] prescale;
   logic tick;
   logic [2:0] next_sync;
   logic next_level;
   logic [7:0] next_prescale;
   logic next_tick;
   logic rise;

   // ==========================================================
   // all timing derives from crystal edges, never from clk_i periods
   always_comb
   begin
      next_sync = {sync[1:0], xtal_i};
      next_level = level;
      if (sync[1] == sync[2])
      begin
         next_level = sync[2];
      end
      rise = next_level & ~level;
      next_prescale = prescale;
      next_tick = 1'b0;
      if (!tif.gate)
      begin
         next_prescale = BYTE_RESET;
      end
      else if (rise)
      begin
         next_prescale = prescale + 8'h01;
         next_tick = (prescale == PRESCALE_LAST);
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sync <= 3'h0;
         level <= 1'b0;
         prescale <= BYTE_RESET;
         tick <= 1'b0;
      end
      else
      begin
         sync <= next_sync;
         level <= next_level;
         prescale <= next_prescale;
         tick <= next_tick;
      end
   end

   assign tif.tick = tick;
endmodule

// File: lit_timekeeper.sv
// fraction, seconds, minutes and hours chain with written-value shadows
`timescale 1ns/10ps
module lit_timekeeper
   import lit_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   lit_time_if.keeper tif
);
   logic [7:0] cnt [FIELDS];
   logic [7:0] shadow [FIELDS];
   logic [7:0] next_cnt [FIELDS];
   logic [7:0] next_shadow [FIELDS];
   logic [FIELDS:0] carry;

   function automatic logic [7:0] field_last(input logic [1:0] idx, input logic day);
      logic [7:0] last;
      last = SIXTY_LAST;
      if (idx == FIELD_FRACTION)
      begin
         last = FRACTION_LAST;
      end
      else if (idx == FIELD_HOURS)
      begin
         last = day ? HOUR_LAST_DAY : HOUR_LAST_FULL;
      end
      return last;
   endfunction

   assign carry[0] = tif.tick & tif.gate;

   genvar i;
   generate
      for (i = 0; i < FIELDS; i++)
      begin : g_field
         logic wrap;
         assign wrap = carry[i] & (cnt[i] >= field_last(2'(i), tif.day_wrap));
         assign carry[i+1] = wrap;
         assign tif.ovf[i] = wrap;
         assign tif.count[i] = cnt[i];

         always_comb
         begin
            next_shadow[i] = shadow[i];
            next_cnt[i] = cnt[i];
            if (tif.wr_en[i])
            begin
               next_shadow[i] = tif.wr_data;
               next_cnt[i] = tif.wr_data;
            end
            else if (!tif.gate)
            begin
               // a stopped clock shows the last written time
               next_cnt[i] = shadow[i];
            end
            else if (wrap)
            begin
               next_cnt[i] = BYTE_RESET;
            end
            else if (carry[i])
            begin
               next_cnt[i] = cnt[i] + 8'h01;
            end
         end

         always_ff @(posedge clk_i)
         begin
            if (rst_i)
            begin
               cnt[i] <= BYTE_RESET;
               shadow[i] <= BYTE_RESET;
            end
            else
            begin
               cnt[i] <= next_cnt[i];
               shadow[i] <= next_shadow[i];
            end
         end
      end
   endgenerate
endmodule

// File: lit_interval_timer.sv
// long interval timekeeper top: wishbone slave, interval counter, wake logic
// How it works
// - timeouts span one 1/128 s tick up to 256 hours via timebase and compare
// - all timekeeping is paced by 32.768 kHz crystal edges, not the core clock
// - time and interval counters keep running during power-down
// - interval counter advances on each tick with timebase 00, else only on overflow of the selected time field
// - counter equal to compare sets match flag (control bit 2), irq if enabled
// - match with irq enabled during power-down wakes core at vector 0053H
// - software may preload time registers and use the block as a clock
// - hours wrap after 23 with day wrap set, after 255 when clear
// - timebase select 00 ticks, 01 seconds, 10 minutes, 11 hours
// - single-shot clears count enable on timeout; otherwise restarts counting
// - fraction counts 0..127 into seconds, seconds 0..59 into minutes
//
// The register offsets and the Wishbone register port were decided locally.
`timescale 1ns/10ps
module lit_interval_timer
   import lit_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic xtal_i,
   input wire logic power_down_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] adr_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   output logic irq_o,
   output logic wake_o,
   output logic [15:0] wake_vector_o
);
   lit_time_if tif();

   lit_tick_gen u_tick
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .xtal_i(xtal_i),
      .tif(tif.gen)
   );

   lit_timekeeper u_keeper
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .tif(tif.keeper)
   );

   // ==========================================================
   // state
   lit_bus_state_t bus_state;
   lit_bus_state_t next_bus_state;
   logic [31:0] rdata;
   logic [31:0] next_rdata;
   logic [7:0] timekeeper_control;
   logic [7:0] next_control;
   logic [7:0] interval_compare_value;
   logic [7:0] next_compare;
   logic [7:0] interval_timekeeper;
   logic [7:0] next_interval;
   logic interval_irq_enable;
   logic next_irq_enable;
   logic irq;
   logic next_irq;
   logic wake;
   logic next_wake;
   logic [15:0] vector;
   logic [15:0] next_vector;
   logic ack;
   logic next_ack;
   logic [FIELDS-1:0] wr_en;
   logic [7:0] wr_data;

   logic time_clock_gate;
   logic interval_count_enable;
   logic interval_match_flag;
   logic single_shot_select;
   logic timebase_select_low;
   logic timebase_select_high;
   logic day_hour_wrap_select;
   logic request;
   logic wr_low;
   logic [4:0] addr;
   logic advance;
   logic [7:0] bumped;
   logic match;

   assign time_clock_gate = timekeeper_control[CTL_GATE];
   assign interval_count_enable = timekeeper_control[CTL_COUNT_EN];
   assign interval_match_flag = timekeeper_control[CTL_FLAG];
   assign single_shot_select = timekeeper_control[CTL_SINGLE];
   assign timebase_select_low = timekeeper_control[CTL_TB_LOW];
   assign timebase_select_high = timekeeper_control[CTL_TB_HIGH];
   assign day_hour_wrap_select = timekeeper_control[CTL_DAY_WRAP];

   assign tif.gate = time_clock_gate;
   assign tif.day_wrap = day_hour_wrap_select;
   assign tif.wr_en = wr_en;
   assign tif.wr_data = wr_data;

   // registers are bytes in lane 0; other lanes are ignored on write
   assign request = cyc_i & stb_i & (bus_state == BUS_IDLE);
   assign wr_low = request & we_i & sel_i[0];
   assign addr = adr_i[ADDR_W-1:0];
   assign wr_data = dat_i[7:0];

   // upper address bits must be zero, so no alias of a register ever hits
   function automatic logic hit(input logic [4:0] a, input logic [4:0] target,
                                input logic [31:0] full);
      return (a == target) && (full[31:ADDR_W] == 27'h0);
   endfunction

   // ==========================================================
   // time field writes
   always_comb
   begin
      wr_en = '0;
      wr_en[FIELD_FRACTION] = wr_low & hit(addr, ADDR_FRACTION, adr_i);
      wr_en[FIELD_SECONDS] = wr_low & hit(addr, ADDR_SECONDS, adr_i);
      wr_en[FIELD_MINUTES] = wr_low & hit(addr, ADDR_MINUTES, adr_i);
      wr_en[FIELD_HOURS] = wr_low & hit(addr, ADDR_HOURS, adr_i);
   end

   // ==========================================================
   // interval counting and match
   always_comb
   begin
      // the tick (timebase 00) or the chosen time field's overflow is the only advance source
      advance = 1'b0;
      case ({timebase_select_high, timebase_select_low})
         2'b00: advance = tif.ovf[FIELD_FRACTION] | tif.tick;
         2'b01: advance = tif.ovf[FIELD_FRACTION];
         2'b10: advance = tif.ovf[FIELD_SECONDS];
         2'b11: advance = tif.ovf[FIELD_MINUTES];
         default: advance = 1'b0;
      endcase
      advance = advance & time_clock_gate & interval_count_enable;
      bumped = interval_timekeeper + 8'h01;
      // a compare value equal to the present count matches only after the count wraps, 256 advances later
      match = advance & (bumped == interval_compare_value);

      next_control = timekeeper_control;
      next_compare = interval_compare_value;
      next_interval = interval_timekeeper;
      next_irq_enable = interval_irq_enable;

      if (wr_low & hit(addr, ADDR_CONTROL, adr_i))
      begin
         next_control = wr_data;
         next_control[7] = 1'b0;
         // software may only clear the flag, never set it
         next_control[CTL_FLAG] = interval_match_flag & wr_data[CTL_FLAG];
      end
      if (wr_low & hit(addr, ADDR_COMPARE, adr_i))
      begin
         next_compare = wr_data;
      end
      // a write to the interval counter loses to an advance in the same cycle
      if (wr_low & hit(addr, ADDR_INTERVAL, adr_i))
      begin
         next_interval = wr_data;
      end
      if (wr_low & hit(addr, ADDR_IRQ_ENABLE, adr_i))
      begin
         next_irq_enable = wr_data[0];
      end

      if (!time_clock_gate)
      begin
         next_interval = BYTE_RESET;
      end
      else if (match)
      begin
         next_control[CTL_FLAG] = 1'b1;
         next_interval = BYTE_RESET;
         if (single_shot_select)
         begin
            next_control[CTL_COUNT_EN] = 1'b0;
         end
      end
      else if (advance)
      begin
         next_interval = bumped;
      end
   end

   // ==========================================================
   // interrupt request and power-down wake
   always_comb
   begin
      next_irq = next_control[CTL_FLAG] & next_irq_enable;
      next_wake = 1'b0;
      next_vector = vector;
      if (match & interval_irq_enable & power_down_i)
      begin
         next_wake = 1'b1;
         next_vector = WAKE_VECTOR;
      end
   end

   // ==========================================================
   // wishbone classic slave, one wait state, ack for one cycle
   // no slow-rate wait: software pacing covers the crystal-rate access limit
   always_comb
   begin
      next_bus_state = BUS_IDLE;
      next_rdata = rdata;
      next_ack = 1'b0;
      case (bus_state)
         BUS_IDLE:
         begin
            if (request)
            begin
               next_bus_state = BUS_ACK;
               next_ack = 1'b1;
               next_rdata = 32'h0;
               if (!we_i)
               begin
                  if (hit(addr, ADDR_CONTROL, adr_i))
                     next_rdata[7:0] = timekeeper_control;
                  else if (hit(addr, ADDR_COMPARE, adr_i))
                     next_rdata[7:0] = interval_compare_value;
                  else if (hit(addr, ADDR_FRACTION, adr_i))
                     next_rdata[7:0] = tif.count[FIELD_FRACTION];
                  else if (hit(addr, ADDR_SECONDS, adr_i))
                     next_rdata[7:0] = tif.count[FIELD_SECONDS];
                  else if (hit(addr, ADDR_MINUTES, adr_i))
                     next_rdata[7:0] = tif.count[FIELD_MINUTES];
                  else if (hit(addr, ADDR_HOURS, adr_i))
                     next_rdata[7:0] = tif.count[FIELD_HOURS];
                  else if (hit(addr, ADDR_INTERVAL, adr_i))
                     next_rdata[7:0] = interval_timekeeper;
                  else if (hit(addr, ADDR_IRQ_ENABLE, adr_i))
                     next_rdata[0] = interval_irq_enable;
               end
            end
         end
         BUS_ACK: next_bus_state = BUS_IDLE;
         default: next_bus_state = BUS_IDLE;
      endcase
   end

   // single clock domain: the crystal is only sampled, so no value is caught mid-change
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         bus_state <= BUS_IDLE;
         rdata <= 32'h0;
         ack <= 1'b0;
      end
      else
      begin
         bus_state <= next_bus_state;
         rdata <= next_rdata;
         ack <= next_ack;
      end
   end

   // ==========================================================
   // control, compare, interval and enable registers
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         timekeeper_control <= CONTROL_RESET;
         interval_compare_value <= BYTE_RESET;
         interval_timekeeper <= BYTE_RESET;
         interval_irq_enable <= 1'b0;
      end
      else
      begin
         timekeeper_control <= next_control;
         interval_compare_value <= next_compare;
         interval_timekeeper <= next_interval;
         interval_irq_enable <= next_irq_enable;
      end
   end

   // ==========================================================
   // interrupt and wake registers
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         irq <= 1'b0;
         wake <= 1'b0;
         vector <= 16'h0000;
      end
      else
      begin
         irq <= next_irq;
         wake <= next_wake;
         vector <= next_vector;
      end
   end

   assign dat_o = rdata;
   // own flop so the bus never sees a state decode on its answer
   assign ack_o = ack;
   assign irq_o = irq;
   assign wake_o = wake;
   assign wake_vector_o = vector;
endmodule

// File: lit_interval_timer_checker.sv
// concurrent checks on the interval timekeeper bus, interrupt and wake outputs
`timescale 1ns/10ps
module lit_interval_timer_checker
   import lit_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic power_down_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] adr_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   input wire logic irq_o,
   input wire logic wake_o,
   input wire logic [15:0] wake_vector_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // ==========================================================
   // bus answers
   property p_ack_pulse;
      ack_o |=> !ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
   property p_ack_cause;
      ack_o |-> $past(cyc_i && stb_i);
   endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
   property p_ack_prompt;
      $rose(cyc_i && stb_i) |=> ack_o;
   endproperty
   a_ack_prompt: assert property (p_ack_prompt) else $error("ack late");
   property p_unmapped_zero;
      ack_o && $past(!we_i && adr_i[31:5] != 27'h0) |-> dat_o == 32'h0;
   endproperty
   a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped data");

   // ==========================================================
   // interrupt and wake
   property p_irq_masked;
      cyc_i && stb_i && we_i && sel_i[0] && !ack_o && !dat_i[0]
         && adr_i == {27'h0, ADDR_IRQ_ENABLE} |-> ##2 !irq_o;
   endproperty
   a_irq_masked: assert property (p_irq_masked) else $error("irq not masked");
   property p_wake_cause;
      wake_o |-> power_down_i || $past(power_down_i) || $past(power_down_i, 2);
   endproperty
   a_wake_cause: assert property (p_wake_cause) else $error("wake while awake");
   property p_wake_pulse;
      wake_o |=> !wake_o;
   endproperty
   a_wake_pulse: assert property (p_wake_pulse) else $error("wake held");
   property p_wake_vector;
      wake_o |=> wake_vector_o == 16'h0053;
   endproperty
   a_wake_vector: assert property (p_wake_vector) else $error("wrong vector");
   property p_vector_hold;
      wake_vector_o != 16'h0000 |=> $stable(wake_vector_o);
   endproperty
   a_vector_hold: assert property (p_vector_hold) else $error("vector moved");

   c_wake: cover property (wake_o);
   c_irq: cover property ($rose(irq_o));
   c_unmapped: cover property (ack_o && $past(adr_i[31:5] != 27'h0));
endmodule

bind lit_interval_timer lit_interval_timer_checker lit_interval_timer_checker_inst (
   .clk_i(clk_i), .rst_i(rst_i), .power_down_i(power_down_i), .cyc_i(cyc_i),
   .stb_i(stb_i), .we_i(we_i), .sel_i(sel_i), .adr_i(adr_i), .dat_i(dat_i),
   .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o), .wake_o(wake_o),
   .wake_vector_o(wake_vector_o));

// File: tb_lit_interval_timer.sv
// self-checking bench for the long interval timekeeper
`timescale 1ns/10ps
module tb_lit_interval_timer;
   import lit_pkg::*;
   // crystal sped up so that one tick takes 256 x 8 core cycles
   localparam int TICK = 2048;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic xtal_i = 1'b0;
   logic power_down_i = 1'b0;
   logic cyc_i = 1'b0;
   logic stb_i = 1'b0;
   logic we_i = 1'b0;
   logic [3:0] sel_i = 4'h0;
   logic [31:0] adr_i = 32'h0;
   logic [31:0] dat_i = 32'h0;
   logic [31:0] dat_o;
   logic ack_o;
   logic irq_o;
   logic wake_o;
   logic [15:0] wake_vector_o;
   logic [2:0] xdiv = 3'h0;
   int miscompares = 0;
   int checks = 0;
   int wakes = 0;

   lit_interval_timer lit_interval_timer_inst (.clk_i(clk_i), .rst_i(rst_i),
      .xtal_i(xtal_i), .power_down_i(power_down_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .sel_i(sel_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
      .ack_o(ack_o), .irq_o(irq_o), .wake_o(wake_o), .wake_vector_o(wake_vector_o));

   always #2.5 clk_i = ~clk_i;

   always @(posedge clk_i)
   begin
      xdiv <= xdiv + 3'h1;
      xtal_i <= xdiv[2];
      if (wake_o === 1'b1)
         wakes <= wakes + 1;
   end

   // ==========================================================
   // shared helpers
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic bus(input logic [31:0] a, input logic w, input logic [7:0] d,
                      output logic [31:0] q);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      sel_i <= 4'h1;
      adr_i <= a;
      dat_i <= {24'h0, d};
      // only the watchdog ends a wait for an answer that never comes
      do
      begin
         @(posedge clk_i);
      end
      while (ack_o !== 1'b1);
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
      @(posedge clk_i);
      chk("ack drop", 32'h0, {31'h0, ack_o});
   endtask

   task automatic wr(input logic [31:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(a, 1'b1, d, q);
   endtask

   task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(a, 1'b0, 8'h00, q);
      chk($sformatf("reg %h", a), exp, q);
   endtask

   task automatic load(input logic [7:0] f, s, m, h, cmp);
      wr(ADDR_CONTROL, 8'h00);
      wr(ADDR_FRACTION, f);
      wr(ADDR_SECONDS, s);
      wr(ADDR_MINUTES, m);
      wr(ADDR_HOURS, h);
      wr(ADDR_COMPARE, cmp);
      wr(ADDR_INTERVAL, 8'h00);
   endtask

   task automatic ticks(input int n);
      repeat (n * TICK + 40) @(posedge clk_i);
   endtask

   // ==========================================================
   // scenarios
   task automatic t_reset();
      rd_chk(ADDR_CONTROL, 32'h0);
      rd_chk(ADDR_HOURS, 32'h0);
      rd_chk(32'h20, 32'h0);
      wr(ADDR_COMPARE, 8'hFF);
      rd_chk(ADDR_COMPARE, 32'hFF);
      chk("vector", 32'h0, {16'h0, wake_vector_o});
      $display("test reset done");
   endtask

   task automatic t_carry(input logic [7:0] ctl, h, hexp);
      load(8'h7F, 8'h3B, 8'h3B, h, 8'h00);
      wr(ADDR_CONTROL, ctl);
      ticks(1);
      rd_chk(ADDR_FRACTION, 32'h0);
      rd_chk(ADDR_SECONDS, 32'h0);
      rd_chk(ADDR_MINUTES, 32'h0);
      rd_chk(ADDR_HOURS, {24'h0, hexp});
      $display("test carry done");
   endtask

   task automatic t_match();
      load(8'h00, 8'h00, 8'h00, 8'h00, 8'h02);
      wr(ADDR_IRQ_ENABLE, 8'h01);
      rd_chk(ADDR_IRQ_ENABLE, 32'h1);
      power_down_i <= 1'b1;
      wr(ADDR_CONTROL, 8'h03);
      ticks(1);
      rd_chk(ADDR_INTERVAL, 32'h1);
      chk("irq", 32'h0, {31'h0, irq_o});
      ticks(1);
      rd_chk(ADDR_CONTROL, 32'h07);
      rd_chk(ADDR_INTERVAL, 32'h0);
      chk("irq", 32'h1, {31'h0, irq_o});
      chk("wakes", 32'h1, wakes);
      chk("vector", 32'h53, {16'h0, wake_vector_o});
      power_down_i <= 1'b0;
      wr(ADDR_IRQ_ENABLE, 8'h00);
      repeat (2) @(posedge clk_i);
      chk("irq", 32'h0, {31'h0, irq_o});
      wr(ADDR_CONTROL, 8'h03);
      rd_chk(ADDR_CONTROL, 32'h03);
      $display("test match done");
   endtask

   task automatic t_single();
      load(8'h00, 8'h00, 8'h00, 8'h00, 8'h01);
      wr(ADDR_CONTROL, 8'h0B);
      ticks(1);
      rd_chk(ADDR_CONTROL, 32'h0D);
      chk("irq", 32'h0, {31'h0, irq_o});
      ticks(1);
      rd_chk(ADDR_INTERVAL, 32'h0);
      chk("wakes", 32'h1, wakes);
      $display("test single done");
   endtask

   task automatic t_base(input logic [1:0] code, input logic [7:0] s, m, input logic hit);
      load(8'h7F, s, m, 8'h00, 8'h01);
      wr(ADDR_CONTROL, {2'b00, code, 4'h3});
      ticks(1);
      rd_chk(ADDR_CONTROL, {26'h0, code, 1'b0, hit, 2'b11});
      $display("test timebase %0d done", code);
   endtask

   task automatic finish_test();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial
   begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_carry(8'h41, 8'h17, 8'h00);
      t_carry(8'h01, 8'h17, 8'h18);
      t_carry(8'h01, 8'hFF, 8'h00);
      t_match();
      t_single();
      t_base(2'b00, 8'h00, 8'h00, 1'b1);
      t_base(2'b01, 8'h00, 8'h00, 1'b1);
      t_base(2'b10, 8'h3B, 8'h00, 1'b1);
      t_base(2'b11, 8'h3B, 8'h3B, 1'b1);
      t_base(2'b10, 8'h00, 8'h00, 1'b0);
      t_base(2'b11, 8'h3B, 8'h00, 1'b0);
      finish_test();
   end

   initial
   begin
      repeat (60000) @(posedge clk_i);
      miscompares++;
      $display("CHECK FAILED watchdog expected done seen hang");
      finish_test();
   end
endmodule
